// ===== usr_pkg.sv
`default_nettype none
// =====================================================================
// Shared constants and types of the universal shift register
package usr_pkg;

  // =====================================================================
  // Register map, byte addresses on the APB
  localparam logic [7:0] USR_OFS_CTRL = 8'h00;
  localparam logic [7:0] USR_OFS_STATUS = 8'h04;
  localparam logic [7:0] USR_OFS_DATA = 8'h08;

  // =====================================================================
  // Field positions
  localparam int USR_CTRL_CAPTURE_BIT = 0;
  localparam int USR_ST_STAGE_LSB = 0;
  localparam int USR_ST_MODE_LSB = 8;
  localparam int USR_ST_DRIVE_BIT = 10;
  localparam int USR_ST_EMPTY_BIT = 11;
  localparam int USR_ST_FULL_BIT = 12;
  localparam int USR_ST_OVF_BIT = 16;
  localparam int USR_ST_LEVEL_LSB = 20;

  // =====================================================================
  // Reset values and sizes
  localparam logic [31:0] USR_CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] USR_STAGE_RESET = 8'h00;
  localparam int USR_STAGES = 8;
  localparam int USR_FIFO_DEPTH = 8;

  // =====================================================================
  // Mode select pair, coded as {high, low}
  typedef struct packed {
    logic high;
    logic low;
  } usr_mode_t;

  localparam logic [1:0] USR_MODE_HOLD = 2'h0;
  localparam logic [1:0] USR_MODE_RIGHT = 2'h1;
  localparam logic [1:0] USR_MODE_LEFT = 2'h2;
  localparam logic [1:0] USR_MODE_LOAD = 2'h3;

  // Bus drive disables travel together
  typedef struct packed {
    logic dis_a;
    logic dis_b;
  } usr_drive_t;

  // APB answer machine
  typedef enum logic [1:0] {
    USR_APB_IDLE = 2'b01,
    USR_APB_ACK = 2'b10
  } usr_apb_state_t;

endpackage
`default_nettype wire

// ===== usr_shift_register.sv
// Function
// R1: Eight clocked stages with steering for shift left, shift right, load and hold.
// R2: The two mode selects alone pick the operation at each clock edge.
// R3: Clear low forces all stages low at once, without the clock.
// R4: Apart from clear, stored value changes only on a rising clock edge. Here presetn low also clears the stages at once.
// R5: Both selects high loads each bus pin level into its stage.
// R6: High low, low high shifts up; right serial input enters stage 0.
// R7: High high, low low shifts down; left serial input enters stage 7.
// R8: Both selects low keeps the stored contents unchanged.
// R9: Each stage drives its own bus pin through a three-state buffer.
// R10: Stage 0 and stage 7 also drive always-active serial outputs.
// R11: Either drive disable high releases all eight bus pins.
// R12: Released bus pins do not stop shifting, loading, holding or clearing.
// R13: Both selects high also releases the bus pins for load data.
// R14: Outside logic drives the bus only while the device has released it.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Capture FIFO, width and depth set its structure
module usr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r, wptr_nxt;
  logic [AW-1:0] rptr_r, rptr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic full_r, full_nxt;
  logic empty_r, empty_nxt;
  logic push, pop;

  assign in_ready = ~full_r;
  assign out_valid = ~empty_r;
  assign out_data = mem[rptr_r];
  assign level = count_r;
  assign push = in_valid & ~full_r;
  assign pop = out_ready & ~empty_r;

  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    count_nxt = count_r;
    if (push) begin
      wptr_nxt = (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
    end
    if (pop) begin
      rptr_nxt = (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
    full_nxt = (count_nxt == (AW+1)'(DEPTH));
    empty_nxt = (count_nxt == '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      count_r <= count_nxt;
      full_r <= full_nxt;
      empty_r <= empty_nxt;
    end
  end

  // Storage needs no reset; the pointers guard stale words
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end

endmodule

// =====================================================================
// Universal shift and storage register with APB access
module usr_shift_register #(
  parameter int STAGES = 8,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic async_clear_n,
  input wire logic mode_sel_low,
  input wire logic mode_sel_high,
  input wire logic serial_in_right,
  input wire logic serial_in_left,
  input wire logic bus_drive_disable_a,
  input wire logic bus_drive_disable_b,
  input wire logic [STAGES-1:0] stage_in,
  output logic [STAGES-1:0] stage_value,
  output logic [STAGES-1:0] stage_oe,
  output logic serial_out_first,
  output logic serial_out_last,
  output logic capture_ready
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  usr_pkg::usr_mode_t mode;
  usr_pkg::usr_drive_t drive;
  usr_pkg::usr_apb_state_t apb_r, apb_nxt;

  logic [STAGES-1:0] stage_r, stage_nxt;
  logic oe_r, oe_nxt;
  logic capture_en_r, capture_en_nxt;
  logic ovf_r, ovf_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [31:0] rd_value;
  logic mapped;
  logic access, wr_access, rd_access;
  logic cap_valid, cap_ready;
  logic pop_valid, pop_req;
  logic [STAGES-1:0] pop_data;
  logic [LW-1:0] level;

  assign mode = '{high: mode_sel_high, low: mode_sel_low};
  assign drive = '{dis_a: bus_drive_disable_a, dis_b: bus_drive_disable_b};

  // =====================================================================
  // Stage steering
  always_comb begin
    stage_nxt = stage_r;
    case ({mode.high, mode.low}) // R2
      usr_pkg::USR_MODE_LOAD: stage_nxt = stage_in; // R5
      usr_pkg::USR_MODE_RIGHT: stage_nxt = {stage_r[STAGES-2:0], serial_in_right}; // R6
      usr_pkg::USR_MODE_LEFT: stage_nxt = {serial_in_left, stage_r[STAGES-1:1]}; // R7
      usr_pkg::USR_MODE_HOLD: stage_nxt = stage_r; // R8
      default: stage_nxt = stage_r;
    endcase
  end

  // Clear and presetn act at once; otherwise stage contents change on the rising edge only
  always_ff @(posedge pclk or negedge presetn or negedge async_clear_n) begin // R4
    if (!presetn || !async_clear_n) begin
      stage_r <= usr_pkg::USR_STAGE_RESET[STAGES-1:0]; // R3
    end else begin
      stage_r <= stage_nxt; // R1 R12
    end
  end

  // =====================================================================
  // Bus drive enable; registered, so it follows the inputs by one edge
  always_comb begin
    oe_nxt = 1'b1;
    if (drive.dis_a || drive.dis_b) begin
      oe_nxt = 1'b0; // R11
    end
    if (mode.high && mode.low) begin
      oe_nxt = 1'b0; // R13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
    end
  end

  assign stage_value = stage_r; // R9
  assign stage_oe = {STAGES{oe_r}}; // R9
  assign serial_out_first = stage_r[0]; // R10
  assign serial_out_last = stage_r[STAGES-1]; // R10

  // =====================================================================
  // Capture path: every shift or load step is offered to the FIFO
  assign cap_valid = capture_en_r && async_clear_n && (mode.high || mode.low);
  assign capture_ready = cap_ready;

  usr_fifo #(
    .WIDTH(STAGES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(cap_valid),
    .in_ready(cap_ready),
    .in_data(stage_nxt),
    .out_valid(pop_valid),
    .out_ready(pop_req),
    .out_data(pop_data),
    .level(level)
  );

  // =====================================================================
  // APB slave, one wait-free answer per transfer
  assign mapped = (paddr == usr_pkg::USR_OFS_CTRL) ||
                  (paddr == usr_pkg::USR_OFS_STATUS) ||
                  (paddr == usr_pkg::USR_OFS_DATA);
  assign access = (apb_r == usr_pkg::USR_APB_ACK) && psel && penable;
  assign wr_access = access && pwrite && mapped;
  assign rd_access = access && !pwrite && mapped;
  assign pop_req = rd_access && (paddr == usr_pkg::USR_OFS_DATA);

  always_comb begin
    rd_value = '0;
    case (paddr)
      usr_pkg::USR_OFS_CTRL: begin
        rd_value[usr_pkg::USR_CTRL_CAPTURE_BIT] = capture_en_r;
      end
      usr_pkg::USR_OFS_STATUS: begin
        rd_value[usr_pkg::USR_ST_STAGE_LSB +: STAGES] = stage_r;
        rd_value[usr_pkg::USR_ST_MODE_LSB +: 2] = {mode.high, mode.low};
        rd_value[usr_pkg::USR_ST_DRIVE_BIT] = oe_r;
        rd_value[usr_pkg::USR_ST_EMPTY_BIT] = ~pop_valid;
        rd_value[usr_pkg::USR_ST_FULL_BIT] = ~cap_ready;
        rd_value[usr_pkg::USR_ST_OVF_BIT] = ovf_r;
        rd_value[usr_pkg::USR_ST_LEVEL_LSB +: LW] = level;
      end
      usr_pkg::USR_OFS_DATA: begin
        // An empty FIFO reads as zero and is not popped
        if (pop_valid) begin
          rd_value[STAGES-1:0] = pop_data;
        end
      end
      default: rd_value = '0;
    endcase
  end

  always_comb begin
    apb_nxt = apb_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = '0;
    case (apb_r)
      usr_pkg::USR_APB_IDLE: begin
        if (psel && !penable) begin
          apb_nxt = usr_pkg::USR_APB_ACK;
          pready_nxt = 1'b1;
          pslverr_nxt = ~mapped;
          prdata_nxt = pwrite ? 32'h0000_0000 : rd_value;
        end
      end
      usr_pkg::USR_APB_ACK: begin
        apb_nxt = usr_pkg::USR_APB_IDLE;
      end
      default: apb_nxt = usr_pkg::USR_APB_IDLE;
    endcase
  end

  // Control and sticky overflow; a new overflow beats a clear
  always_comb begin
    capture_en_nxt = capture_en_r;
    ovf_nxt = ovf_r;
    if (wr_access && paddr == usr_pkg::USR_OFS_CTRL) begin
      capture_en_nxt = pwdata[usr_pkg::USR_CTRL_CAPTURE_BIT];
    end
    if (wr_access && paddr == usr_pkg::USR_OFS_STATUS && pwdata[usr_pkg::USR_ST_OVF_BIT]) begin
      ovf_nxt = 1'b0;
    end
    if (cap_valid && !cap_ready) begin
      ovf_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_r <= usr_pkg::USR_APB_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      capture_en_r <= usr_pkg::USR_CTRL_RESET[usr_pkg::USR_CTRL_CAPTURE_BIT];
      ovf_r <= 1'b0;
    end else begin
      apb_r <= apb_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      capture_en_r <= capture_en_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

endmodule
`default_nettype wire

// ===== usr_shift_register_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================
// Stage steering and bus release checks
module usr_shift_register_chk #(
  parameter int STAGES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_clear_n,
  input wire logic mode_sel_low,
  input wire logic mode_sel_high,
  input wire logic serial_in_right,
  input wire logic serial_in_left,
  input wire logic bus_drive_disable_a,
  input wire logic bus_drive_disable_b,
  input wire logic [STAGES-1:0] stage_in,
  input wire logic [STAGES-1:0] stage_value,
  input wire logic [STAGES-1:0] stage_oe,
  input wire logic serial_out_first,
  input wire logic serial_out_last
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Clear must stay inactive over the whole step, else it wins
  sequence s_run(logic [1:0] m);
    async_clear_n && {mode_sel_high, mode_sel_low} == m ##1 async_clear_n;
  endsequence
  property p_clear;
    !async_clear_n |-> stage_value == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("stages not cleared");
  property p_hold;
    s_run(usr_pkg::USR_MODE_HOLD) |-> $stable(stage_value);
  endproperty
  a_hold: assert property (p_hold) else $error("hold changed stages");
  property p_right;
    s_run(usr_pkg::USR_MODE_RIGHT) |->
      stage_value == {$past(stage_value[STAGES-2:0]), $past(serial_in_right)};
  endproperty
  a_right: assert property (p_right) else $error("bad shift up");
  property p_left;
    s_run(usr_pkg::USR_MODE_LEFT) |->
      stage_value == {$past(serial_in_left), $past(stage_value[STAGES-1:1])};
  endproperty
  a_left: assert property (p_left) else $error("bad shift down");
  property p_load;
    s_run(usr_pkg::USR_MODE_LOAD) |-> stage_value == $past(stage_in);
  endproperty
  a_load: assert property (p_load) else $error("bad parallel load");
  property p_serial;
    async_clear_n |->
      serial_out_first == stage_value[0] && serial_out_last == stage_value[STAGES-1];
  endproperty
  a_serial: assert property (p_serial) else $error("serial outs differ");
  property p_release;
    bus_drive_disable_a || bus_drive_disable_b |=> stage_oe == '0;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_load_release;
    mode_sel_high && mode_sel_low |=> stage_oe == '0;
  endproperty
  a_load_release: assert property (p_load_release) else $error("driven in load");
  // Sampled reset keeps the release edge out: the enable flop still holds its reset value there
  property p_drive;
    presetn && !bus_drive_disable_a && !bus_drive_disable_b && !(mode_sel_high && mode_sel_low)
      |=> stage_oe == '1;
  endproperty
  a_drive: assert property (p_drive) else $error("bus not driven");
endmodule

bind usr_shift_register usr_shift_register_chk #(.STAGES(STAGES)) u_chk (
  .pclk, .presetn, .async_clear_n, .mode_sel_low, .mode_sel_high, .serial_in_right,
  .serial_in_left, .bus_drive_disable_a, .bus_drive_disable_b, .stage_in, .stage_value,
  .stage_oe, .serial_out_first, .serial_out_last);
`default_nettype wire

// ===== usr_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================
// Far bus logic: drives load data only onto released pins
module usr_bus_model (
  input wire logic [7:0] stage_oe,
  input wire logic [7:0] stage_value,
  input wire logic [7:0] load_data,
  output logic [7:0] stage_in
);
  assign stage_in = (stage_oe & stage_value) | (~stage_oe & load_data);
endmodule
`default_nettype wire

// ===== usr_shift_register_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================
// Directed sequences over APB and the stage pins
module usr_shift_register_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, load_data, stage_in, stage_value, stage_oe, s;
  logic [31:0] pwdata, prdata, v;
  logic async_clear_n, serial_in_right, serial_in_left, capture_ready;
  logic serial_out_first, serial_out_last;
  usr_pkg::usr_mode_t mode;
  usr_pkg::usr_drive_t dis;
  logic [7:0] q[$];
  int bad_count, n_checks;

  usr_shift_register dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .async_clear_n, .mode_sel_low(mode.low),
    .mode_sel_high(mode.high), .serial_in_right, .serial_in_left,
    .bus_drive_disable_a(dis.dis_a), .bus_drive_disable_b(dis.dis_b), .stage_in,
    .stage_value, .stage_oe, .serial_out_first, .serial_out_last, .capture_ready);
  usr_bus_model far (.stage_oe, .stage_value, .load_data, .stage_in);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Ends one edge after release so the next setup never lands in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    v = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(v, exp);
  endtask

  // Stages sampled after the extra hold edge show the result of all n steps
  task automatic run(input logic [1:0] m, input int n);
    mode <= usr_pkg::usr_mode_t'(m);
    repeat (n) @(posedge pclk);
    mode <= usr_pkg::usr_mode_t'(usr_pkg::USR_MODE_HOLD);
    @(posedge pclk);
  endtask

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    #10000;
    bad_count++;
    complete_run;
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    async_clear_n = 1'h1;
    serial_in_right = 1'h1;
    serial_in_left = 1'h0;
    mode = 2'h0;
    dis = 2'h0;
    load_data = 8'ha5;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    check({stage_value, stage_oe, capture_ready}, 17'h1);
    presetn <= 1'h1;
    @(posedge pclk);
    run(usr_pkg::USR_MODE_LOAD, 2);
    check(stage_value, 8'ha5);
    check(stage_oe, 8'h00);
    run(usr_pkg::USR_MODE_RIGHT, 1);
    check({serial_out_last, serial_out_first, stage_value}, 10'h14b);
    check(stage_oe, 8'hff);
    dis <= 2'h2;
    run(usr_pkg::USR_MODE_LEFT, 1);
    check(stage_value, 8'h25);
    check(stage_oe, 8'h00);
    dis <= 2'h1;
    run(usr_pkg::USR_MODE_HOLD, 3);
    check({stage_oe, stage_value}, 16'h0025);
    dis <= 2'h0;
    // Drive flag follows the disables one edge late
    @(posedge pclk);
    rd(usr_pkg::USR_OFS_STATUS, 32'h0000_0c25);
    apb(1'h1, usr_pkg::USR_OFS_CTRL, 32'h1);
    rd(usr_pkg::USR_OFS_CTRL, 32'h1);
    s = 8'h25;
    for (int i = 0; i < 10; i++) begin
      s = {s[6:0], 1'h1};
      if (i < 8) q.push_back(s);
    end
    run(usr_pkg::USR_MODE_RIGHT, 10);
    check({capture_ready, stage_value}, 9'h0ff);
    rd(usr_pkg::USR_OFS_STATUS, 32'h0081_14ff);
    apb(1'h1, usr_pkg::USR_OFS_STATUS, 32'h0001_0000);
    repeat (8) rd(usr_pkg::USR_OFS_DATA, {24'h0, q.pop_front()});
    rd(usr_pkg::USR_OFS_DATA, 32'h0);
    rd(usr_pkg::USR_OFS_STATUS, 32'h0000_0cff);
    apb(1'h0, 8'h0c, 32'h0);
    check(e, 1'h1);
    mode <= usr_pkg::usr_mode_t'(usr_pkg::USR_MODE_RIGHT);
    async_clear_n <= 1'h0;
    #1;
    check(stage_value, 8'h00);
    repeat (2) @(posedge pclk);
    check(stage_value, 8'h00);
    async_clear_n <= 1'h1;
    load_data <= 8'h3c;
    run(usr_pkg::USR_MODE_LOAD, 2);
    check(stage_value, 8'h3c);
    complete_run;
  end
endmodule
`default_nettype wire
